// ---- rsq_defines.svh ----
// Constants of the reset sequencer and supply monitor: offsets, fields,
// reset values and timing counts. Included by the sequencer module only.
`ifndef RSQ_DEFINES_SVH
`define RSQ_DEFINES_SVH

// Register word indices on the Avalon slave (byte address = 4 * index)
`define RSQ_ADDR_STATUS 2'h0
`define RSQ_ADDR_OPTION 2'h1

// Status/control register fields
`define RSQ_BIT_IRQ_EN 0
`define RSQ_BIT_WARN 1
`define RSQ_BIT_LOWV_RF 2
`define RSQ_BIT_LOCK 3
`define RSQ_BIT_WDG_RF 4
`define RSQ_STATUS_W 5

// Option register fields and reset value
`define RSQ_OPT_CLK_LSB 0
`define RSQ_OPT_PLL_EN 2
`define RSQ_OPT_LOWV_EN 3
`define RSQ_OPT_THR_LSB 4
`define RSQ_OPT_W 6
`define RSQ_OPTION_RESET 6'h08

// Sequence timing
`define RSQ_DELAY_SHORT 256
`define RSQ_DELAY_LONG 4096
`define RSQ_FETCH_CYCLES 2
`define RSQ_VEC_LO 16'hFFFE
`define RSQ_VEC_HI 16'hFFFF
`define RSQ_CLK_MHZ 125
`define RSQ_WDG_PULSE_NS 200
`define RSQ_WDG_PULSE_CYC ((`RSQ_WDG_PULSE_NS * `RSQ_CLK_MHZ + 999) / 1000)

`endif

// ---- rsq_pkg.sv ----
// Types of the reset sequencer: sequence states and option encodings.
// No assumptions beyond a SystemVerilog compiler.
package rsq_pkg;

	typedef enum logic [4:0] {
		RSQ_ST_ACTIVE = 5'h01,
		RSQ_ST_DELAY = 5'h02,
		RSQ_ST_PLLW = 5'h04,
		RSQ_ST_FETCH = 5'h08,
		RSQ_ST_RUN = 5'h10
	} rsq_state_t;

	typedef enum logic [1:0] {
		RSQ_CLK_RC = 2'h0,
		RSQ_CLK_EXT = 2'h1,
		RSQ_CLK_XTAL = 2'h2
	} rsq_clk_src_t;

	typedef enum logic [1:0] {
		RSQ_THR_LOW = 2'h0,
		RSQ_THR_MED = 2'h1,
		RSQ_THR_HIGH = 2'h2
	} rsq_threshold_t;

endpackage : rsq_pkg

// ---- rsq_delay_counter.sv ----
// Delay phase counter of the reset sequencer.
// Assumes a synchronous run level; dropping it restarts the count from zero.
`timescale 1ns/1ps

module rsq_delay_counter #(
	parameter int CNT_W = 13
) (
	input wire logic i_clk_sys, // System clock
	input wire logic i_rst_n, // Synchronised reset, active low
	input wire logic i_run, // Count while high
	input wire logic [CNT_W-1:0] i_limit, // Cycles in the phase
	output logic o_done, // Last cycle of the phase
	output logic [CNT_W-1:0] o_count // Cycles counted so far
);

	logic [CNT_W-1:0] count_reg;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_reg <= '0;
		end else if (!i_run) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_reg + 1'b1;
		end
	end

	assign o_done = i_run && (count_reg == i_limit - 1'b1);
	assign o_count = count_reg;

endmodule : rsq_delay_counter

// ---- rsq_reset_sequencer.sv ----
// Reset sequencer and supply monitor with its Avalon-MM register slave.
// Assumes synchronous source inputs and an external pin resolver for the
// open-drain reset pin.
//
// Summary of operation
// RL1: Drive reset pin low whatever the source, through the whole delay phase.
// RL2: After the delay, fetch the reset vector from FFFEh then FFFFh.
// RL3: Reset runs active phase, then counted delay, then vector fetch.
// RL4: Delay is 256 cycles for RC or external clock, 4096 for crystal.
// RL5: Vector fetch phase lasts exactly two clock cycles.
// RL6: With the multiplier enabled, wait for its lock before the fetch.
// RL7: Pin is input and open drain; pin low enters reset asynchronously.
// RL8: Watchdog underflow drives pin low for at least the minimum pulse.
// RL9: Low supply holds static reset and keeps the pin low.
// RL10: Low-voltage detector is optional, threshold low, medium or high.
// RL11: Without the detector, outside circuitry holds the pin low at power-up.
// RL12: Illegal opcode or prebyte code also starts a reset.
// RL13: Warning flag shows the comparator live and is read only.
// RL14: Warning detector works only while the low-voltage detector is enabled.
// RL15: Enabled warning interrupt is requested when the flag sets.
// RL16: Wait mode unaffected; warning wakes from wait, never from halt.
// RL17: Halt freezes the status register; warning detector stays active.
// RL18: Status resets to 0000 0xx0; bits 7:5 read zero; fields as laid out. Code resets to 0000 x0x0, bit 3 being the live lock bit.
// RL19: Watchdog flag set by watchdog reset, cleared by writing zero or low supply.
// RL20: Low-supply flag set by low-supply reset, cleared by read only.
// RL21: Lock bit is driven only by hardware from the multiplier.
// RL22: Pending warning request clears on entry to its service routine.
// RL23: Delay starts once sources are gone and restarts if one returns.
// RL24: Pin reset is synchronised to the clock before it is released.
`timescale 1ns/1ps
`include "rsq_defines.svh"

module rsq_reset_sequencer #(
	parameter int DELAY_SHORT = `RSQ_DELAY_SHORT,
	parameter int DELAY_LONG = `RSQ_DELAY_LONG,
	parameter int WDG_PULSE_CYC = `RSQ_WDG_PULSE_CYC,
	parameter logic [`RSQ_OPT_W-1:0] OPTION_RESET = `RSQ_OPTION_RESET
) (
	input wire logic i_clk_sys, // System clock, 125 MHz
	input wire logic i_nrst, // Power-on reset, active low
	input wire logic [1:0] i_avs_address, // Avalon word address
	input wire logic i_avs_read, // Avalon read
	input wire logic i_avs_write, // Avalon write
	input wire logic [31:0] i_avs_writedata, // Avalon write data
	output logic [31:0] o_avs_readdata, // Avalon read data
	output logic o_avs_waitrequest, // Avalon wait
	input wire logic i_rst_pin_n, // Reset pin level, low = reset
	output logic o_rst_pin_out, // Reset pin drive value
	output logic o_rst_pin_oe, // Reset pin pull-down enable
	input wire logic i_lowv_below, // Supply below reset threshold
	input wire logic i_auxv_below, // Supply below warning threshold
	input wire logic i_wdg_underflow, // Watchdog underflow pulse
	input wire logic i_illegal_op, // Illegal opcode or prebyte pulse
	input wire logic i_pll_locked, // Multiplier at operating frequency
	input wire logic i_halt, // Core in halt
	input wire logic i_wait, // Core in wait
	input wire logic i_irq_ack, // Warning service routine entered
	output logic o_core_reset, // Core held in reset
	output logic o_vec_fetch, // Vector fetch phase
	output logic [15:0] o_vec_addr, // Vector byte address
	output logic o_lowv_enable, // Low-voltage detector enable
	output logic [1:0] o_lowv_threshold, // Detector threshold select
	output logic o_irq_req, // Warning interrupt request
	output logic o_wake_wait // Wake core from wait
);

	localparam int CNT_W = 13;

	logic rst_s1;
	logic rst_n;
	logic pin_s1;
	logic pin_s2;
	rsq_pkg::rsq_state_t st_reg;
	rsq_pkg::rsq_state_t st_next;
	logic [`RSQ_OPT_W-1:0] opt_reg;
	logic irq_en_reg;
	logic wdg_rf_reg;
	logic lowv_rf_reg;
	logic pend_reg;
	logic warn_q;
	logic ack_reg;
	logic fetch_cnt_reg;
	logic [15:0] vec_reg;
	logic [31:0] rdata_reg;
	logic [7:0] wdg_cnt_reg;
	logic [1:0] drv_hist_reg;
	logic lowv_en;
	logic warn_flag;
	logic lowv_src;
	logic any_int;
	logic ext_src;
	logic any_src;
	logic dly_run;
	logic dly_done;
	logic [CNT_W-1:0] dly_limit;
	logic [CNT_W-1:0] dly_count;
	logic req;
	logic wr_ok;
	logic rd_status;
	logic [`RSQ_STATUS_W-1:0] status;

	// Power-on reset release
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// Pin low asserts at once, release is synchronised
	always_ff @(posedge i_clk_sys or negedge i_rst_pin_n) begin
		if (!i_rst_pin_n) begin
			pin_s1 <= 1'b1; // RL7
			pin_s2 <= 1'b1;
		end else begin
			pin_s1 <= 1'b0;
			pin_s2 <= pin_s1; // RL24
		end
	end

	assign lowv_en = opt_reg[`RSQ_OPT_LOWV_EN];
	assign warn_flag = lowv_en & i_auxv_below; // RL13 RL14
	assign lowv_src = lowv_en & i_lowv_below; // RL10
	assign any_int = lowv_src | (wdg_cnt_reg != 8'h00) | i_wdg_underflow | i_illegal_op; // RL12
	// Own pull-down still reads back low for two cycles through the synchroniser
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			drv_hist_reg <= 2'h3;
		end else begin
			drv_hist_reg <= {drv_hist_reg[0], o_rst_pin_oe};
		end
	end

	assign ext_src = pin_s2 & ~o_rst_pin_oe & ~(|drv_hist_reg); // RL7
	assign any_src = any_int | ext_src;

	// Watchdog pulse stretcher
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wdg_cnt_reg <= 8'h00;
		end else if (i_wdg_underflow) begin
			wdg_cnt_reg <= 8'(WDG_PULSE_CYC); // RL8
		end else if (wdg_cnt_reg != 8'h00) begin
			wdg_cnt_reg <= wdg_cnt_reg - 8'h01;
		end
	end

	assign dly_limit = (opt_reg[`RSQ_OPT_CLK_LSB +: 2] == rsq_pkg::RSQ_CLK_XTAL) ?
		CNT_W'(DELAY_LONG) : CNT_W'(DELAY_SHORT); // RL4
	assign dly_run = (st_reg == rsq_pkg::RSQ_ST_DELAY) && !any_int; // RL23

	rsq_delay_counter #(
		.CNT_W(CNT_W)
	) u_delay (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_n),
		.i_run(dly_run),
		.i_limit(dly_limit),
		.o_done(dly_done),
		.o_count(dly_count)
	);

	always_comb begin
		st_next = st_reg;
		case (st_reg)
			rsq_pkg::RSQ_ST_ACTIVE: begin
				if (!any_int) begin
					st_next = rsq_pkg::RSQ_ST_DELAY; // RL3
				end
			end
			rsq_pkg::RSQ_ST_DELAY: begin
				if (any_int) begin
					st_next = rsq_pkg::RSQ_ST_ACTIVE; // RL23
				end else if (dly_done) begin
					st_next = opt_reg[`RSQ_OPT_PLL_EN] ?
						rsq_pkg::RSQ_ST_PLLW : rsq_pkg::RSQ_ST_FETCH; // RL6
				end
			end
			rsq_pkg::RSQ_ST_PLLW: begin
				if (any_src) begin
					st_next = rsq_pkg::RSQ_ST_ACTIVE;
				end else if (i_pll_locked) begin
					st_next = rsq_pkg::RSQ_ST_FETCH; // RL6
				end
			end
			rsq_pkg::RSQ_ST_FETCH: begin
				if (any_src) begin
					st_next = rsq_pkg::RSQ_ST_ACTIVE;
				end else if (fetch_cnt_reg == 1'(`RSQ_FETCH_CYCLES - 1)) begin
					st_next = rsq_pkg::RSQ_ST_RUN; // RL5
				end
			end
			rsq_pkg::RSQ_ST_RUN: begin
				if (any_src) begin
					st_next = rsq_pkg::RSQ_ST_ACTIVE; // RL7
				end
			end
			default: begin
				st_next = rsq_pkg::RSQ_ST_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= rsq_pkg::RSQ_ST_ACTIVE;
		end else begin
			st_reg <= st_next;
		end
	end

	// Vector fetch phase
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fetch_cnt_reg <= 1'b0;
			vec_reg <= `RSQ_VEC_LO;
		end else begin
			fetch_cnt_reg <= (st_next == rsq_pkg::RSQ_ST_FETCH) &&
				(st_reg == rsq_pkg::RSQ_ST_FETCH);
			if (st_next == rsq_pkg::RSQ_ST_FETCH && st_reg != rsq_pkg::RSQ_ST_FETCH) begin
				vec_reg <= `RSQ_VEC_LO; // RL2
			end else if (st_reg == rsq_pkg::RSQ_ST_FETCH) begin
				vec_reg <= `RSQ_VEC_HI; // RL2
			end
		end
	end

	assign o_rst_pin_out = 1'b0;
	assign o_rst_pin_oe = (st_reg == rsq_pkg::RSQ_ST_ACTIVE) ||
		(st_reg == rsq_pkg::RSQ_ST_DELAY); // RL1 RL9
	assign o_core_reset = (st_reg != rsq_pkg::RSQ_ST_RUN) || pin_s2; // RL7
	assign o_vec_fetch = (st_reg == rsq_pkg::RSQ_ST_FETCH);
	assign o_vec_addr = vec_reg;

	// Avalon slave: one wait cycle, then the answer
	assign req = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_reg;
	assign wr_ok = i_avs_write & ack_reg & ~i_halt; // RL17
	assign rd_status = i_avs_read & ack_reg & ~i_halt &
		(i_avs_address == `RSQ_ADDR_STATUS);
	assign status = {wdg_rf_reg, i_pll_locked, lowv_rf_reg, warn_flag, irq_en_reg}; // RL18 RL21

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (i_avs_read && !ack_reg) begin
				case (i_avs_address)
					`RSQ_ADDR_STATUS: rdata_reg <= {27'h0, status}; // RL18
					`RSQ_ADDR_OPTION: rdata_reg <= {26'h0, opt_reg};
					default: rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign o_avs_readdata = rdata_reg;

	// Option register, steers the sequence and the detector
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			opt_reg <= OPTION_RESET;
		end else if (wr_ok && i_avs_address == `RSQ_ADDR_OPTION) begin
			opt_reg <= i_avs_writedata[`RSQ_OPT_W-1:0];
		end
	end

	assign o_lowv_enable = opt_reg[`RSQ_OPT_LOWV_EN]; // RL10
	assign o_lowv_threshold = opt_reg[`RSQ_OPT_THR_LSB +: 2]; // RL10

	// Interrupt enable
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_reg <= 1'b0;
		end else if (wr_ok && i_avs_address == `RSQ_ADDR_STATUS) begin
			irq_en_reg <= i_avs_writedata[`RSQ_BIT_IRQ_EN];
		end
	end

	// Watchdog reset flag, set wins
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wdg_rf_reg <= 1'b0;
		end else if (i_wdg_underflow) begin
			wdg_rf_reg <= 1'b1; // RL19
		end else if (lowv_src) begin
			wdg_rf_reg <= 1'b0; // RL19
		end else if (wr_ok && i_avs_address == `RSQ_ADDR_STATUS &&
			!i_avs_writedata[`RSQ_BIT_WDG_RF]) begin
			wdg_rf_reg <= 1'b0; // RL19
		end
	end

	// Low-supply reset flag, cleared by reading, set wins
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lowv_rf_reg <= 1'b0;
		end else if (lowv_src) begin
			lowv_rf_reg <= 1'b1; // RL20
		end else if (rd_status) begin
			lowv_rf_reg <= 1'b0; // RL20
		end
	end

	// Warning interrupt pending, set wins over acknowledge
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			warn_q <= 1'b0;
			pend_reg <= 1'b0;
		end else begin
			warn_q <= warn_flag;
			if (warn_flag && !warn_q && irq_en_reg) begin
				pend_reg <= 1'b1; // RL15
			end else if (i_irq_ack || !irq_en_reg) begin
				pend_reg <= 1'b0; // RL22
			end
		end
	end

	assign o_irq_req = pend_reg; // RL15
	assign o_wake_wait = pend_reg & i_wait & ~i_halt; // RL16

	// Helper: cycles spent in the delay phase
	logic [CNT_W-1:0] dly_seen;

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dly_seen <= '0;
		end else if (st_reg == rsq_pkg::RSQ_ST_DELAY) begin
			dly_seen <= dly_seen + 1'b1;
		end else if (st_reg == rsq_pkg::RSQ_ST_ACTIVE) begin
			dly_seen <= '0;
		end
	end

	property p_pin_delay;
		@(posedge i_clk_sys) disable iff (!rst_n)
		st_reg == rsq_pkg::RSQ_ST_DELAY |-> o_rst_pin_oe && o_core_reset;
	endproperty
	a_pin_delay: assert property (p_pin_delay) else $error("pin released in delay"); // RL1

	property p_vector;
		@(posedge i_clk_sys) disable iff (!rst_n)
		$rose(o_vec_fetch) |-> o_vec_addr == `RSQ_VEC_LO ##1 o_vec_addr == `RSQ_VEC_HI;
	endproperty
	a_vector: assert property (p_vector) else $error("wrong vector address"); // RL2

	property p_order;
		@(posedge i_clk_sys) disable iff (!rst_n)
		$rose(st_reg == rsq_pkg::RSQ_ST_DELAY) |-> $past(st_reg) == rsq_pkg::RSQ_ST_ACTIVE;
	endproperty
	a_order: assert property (p_order) else $error("delay not after active"); // RL3

	property p_dly_restart;
		@(posedge i_clk_sys) disable iff (!rst_n)
		$rose(st_reg == rsq_pkg::RSQ_ST_DELAY) |-> dly_count == '0;
	endproperty
	a_dly_restart: assert property (p_dly_restart) else $error("delay count not restarted"); // RL23

	property p_delay_len;
		@(posedge i_clk_sys) disable iff (!rst_n)
		$past(st_reg) == rsq_pkg::RSQ_ST_DELAY && st_reg != rsq_pkg::RSQ_ST_DELAY &&
			st_reg != rsq_pkg::RSQ_ST_ACTIVE |-> dly_seen == dly_limit;
	endproperty
	a_delay_len: assert property (p_delay_len) else $error("delay length wrong"); // RL4

	property p_fetch_len;
		@(posedge i_clk_sys) disable iff (!rst_n)
		$rose(o_vec_fetch) && !any_src |=> o_vec_fetch || o_rst_pin_oe ##1 !o_vec_fetch;
	endproperty
	a_fetch_len: assert property (p_fetch_len) else $error("fetch not two cycles"); // RL5

	property p_pll_wait;
		@(posedge i_clk_sys) disable iff (!rst_n)
		st_reg == rsq_pkg::RSQ_ST_PLLW && !i_pll_locked |=> !o_vec_fetch;
	endproperty
	a_pll_wait: assert property (p_pll_wait) else $error("fetch before lock"); // RL6

	property p_wdg_pulse;
		@(posedge i_clk_sys) disable iff (!rst_n)
		i_wdg_underflow |=> o_rst_pin_oe [*8];
	endproperty
	a_wdg_pulse: assert property (p_wdg_pulse) else $error("watchdog pulse short"); // RL8

	property p_lowv_hold;
		@(posedge i_clk_sys) disable iff (!rst_n)
		lowv_src |=> o_rst_pin_oe && o_core_reset;
	endproperty
	a_lowv_hold: assert property (p_lowv_hold) else $error("pin free at low supply"); // RL9

	property p_illegal;
		@(posedge i_clk_sys) disable iff (!rst_n)
		i_illegal_op |=> st_reg == rsq_pkg::RSQ_ST_ACTIVE;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal op ignored"); // RL12

	property p_warn_off;
		@(posedge i_clk_sys) disable iff (!rst_n)
		!o_lowv_enable |-> !status[`RSQ_BIT_WARN] ##1 !o_irq_req || $past(o_irq_req);
	endproperty
	a_warn_off: assert property (p_warn_off) else $error("warning with detector off"); // RL14

	property p_irq_set;
		@(posedge i_clk_sys) disable iff (!rst_n)
		$rose(warn_flag) && irq_en_reg |=> o_irq_req;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("warning irq not raised"); // RL15

	property p_no_halt_wake;
		@(posedge i_clk_sys) disable iff (!rst_n)
		i_halt |-> !o_wake_wait;
	endproperty
	a_no_halt_wake: assert property (p_no_halt_wake) else $error("woke from halt"); // RL16

	property p_wdg_clear;
		@(posedge i_clk_sys) disable iff (!rst_n)
		lowv_src && !i_wdg_underflow |=> !wdg_rf_reg;
	endproperty
	a_wdg_clear: assert property (p_wdg_clear) else $error("watchdog flag kept"); // RL19

	property p_lowv_rf;
		@(posedge i_clk_sys) disable iff (!rst_n)
		lowv_src |=> lowv_rf_reg;
	endproperty
	a_lowv_rf: assert property (p_lowv_rf) else $error("low supply flag not set"); // RL20

	property p_ack_clear;
		@(posedge i_clk_sys) disable iff (!rst_n)
		i_irq_ack && !($rose(warn_flag) && irq_en_reg) |=> !o_irq_req;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("pending not cleared"); // RL22

endmodule : rsq_reset_sequencer

// ---- rsq_pin_partner.sv ----
// Board reset circuitry sharing the open-drain reset pin with the device.
// Assumes the device gives its pin value and enable; the pin has a pull-up.
`timescale 1ns/1ps

module rsq_pin_partner #(
	parameter int PWRUP_CYC = 4
) (
	input wire logic i_clk_sys, // System clock
	input wire logic i_pull, // Bench asks for a pin pull-down
	input wire logic i_dev_out, // Device pin value
	input wire logic i_dev_oe, // Device pin enable
	output logic o_pin_n // Resolved pin level
);
	logic [3:0] age_reg = 4'h0;
	always_ff @(posedge i_clk_sys) begin
		if (age_reg < PWRUP_CYC) age_reg <= age_reg + 4'h1;
	end
	// Power-up hold, then pull on request or on device drive; pull-up otherwise
	assign o_pin_n = ~((i_dev_oe & ~i_dev_out) | i_pull | (age_reg < PWRUP_CYC));
endmodule : rsq_pin_partner

// ---- testbench.sv ----
// Self-checking bench of the reset sequencer through its Avalon slave.
// Assumes the pin partner resolves the reset pin; delays are shortened.
`timescale 1ns/1ps

module testbench;
	localparam int DS = 8;
	localparam int DL = 16;
	localparam int WP = 6;
	logic i_clk_sys, i_nrst, rd, wr, wq, pin_n, p_out, p_oe, lowv, auxv, wdg, ill;
	logic lock, halt, waitm, ack, crst, vf, lv_en, irq, wake, pull;
	logic [1:0] adr, thr;
	logic [31:0] wd, rdat, q;
	logic [15:0] va;
	int n_mismatch = 0;
	int n_tests = 0;
	int n;

	rsq_reset_sequencer #(.DELAY_SHORT(DS), .DELAY_LONG(DL), .WDG_PULSE_CYC(WP)) u_rsq_reset_sequencer (
		.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
		.i_rst_pin_n(pin_n), .o_rst_pin_out(p_out), .o_rst_pin_oe(p_oe), .i_lowv_below(lowv),
		.i_auxv_below(auxv), .i_wdg_underflow(wdg), .i_illegal_op(ill), .i_pll_locked(lock),
		.i_halt(halt), .i_wait(waitm), .i_irq_ack(ack), .o_core_reset(crst), .o_vec_fetch(vf),
		.o_vec_addr(va), .o_lowv_enable(lv_en), .o_lowv_threshold(thr), .o_irq_req(irq),
		.o_wake_wait(wake));

	rsq_pin_partner u_rsq_pin_partner (.i_clk_sys(i_clk_sys), .i_pull(pull), .i_dev_out(p_out),
		.i_dev_oe(p_oe), .o_pin_n(pin_n));

	initial begin
		i_clk_sys = 1'b0;
		forever #4 i_clk_sys = ~i_clk_sys;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic end_sim();
		$display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	// Hold the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
		logic t;
		int k;
		k = 0;
		@(posedge i_clk_sys);
		adr <= a;
		wd <= d;
		rd <= ~w;
		wr <= w;
		do begin
			@(posedge i_clk_sys);
			t = wq;
			q = rdat;
			k++;
		end while (t !== 1'b0 && k < 20);
		rd <= 1'b0;
		wr <= 1'b0;
		if (k >= 20) chk("bus answer", 0, 1);
	endtask : bus

	task automatic rchk(input logic [1:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("register %0d", a), e, q);
	endtask : rchk

	task automatic pulse(input int s);
		@(posedge i_clk_sys);
		if (s == 0)
			ill <= 1'b1;
		else
			wdg <= 1'b1;
		@(posedge i_clk_sys);
		ill <= 1'b0;
		wdg <= 1'b0;
	endtask : pulse

	// Count pin-drive cycles into n, then follow the vector fetch
	task automatic watch();
		int k;
		k = 0;
		n = 0;
		@(negedge i_clk_sys);
		while (p_oe !== 1'b1 && k < 60) begin
			@(negedge i_clk_sys);
			k++;
		end
		chk("pin driven", 1, p_oe);
		while (p_oe === 1'b1 && n < 9000) begin
			if (pin_n !== 1'b0) chk("pin low", 0, pin_n);
			n++;
			@(negedge i_clk_sys);
		end
		chk("pin released", 0, p_oe);
		k = 0;
		while (vf !== 1'b1 && k < 200) begin
			@(negedge i_clk_sys);
			k++;
		end
		chk("fetch start", 1, vf);
		chk("vector low", 16'hFFFE, va);
		@(negedge i_clk_sys);
		chk("fetch second", 1, vf);
		chk("vector high", 16'hFFFF, va);
		@(negedge i_clk_sys);
		chk("fetch end", 0, vf);
		chk("core run", 0, crst);
	endtask : watch

	initial begin
		#100000;
		chk("timeout", 0, 1);
		end_sim();
	end

	initial begin
		{i_nrst, rd, wr, lowv, auxv, wdg, ill, lock, halt, waitm, ack, pull} <= 12'h000;
		adr <= 2'h0;
		wd <= 32'h0;
		repeat (3) @(posedge i_clk_sys);
		i_nrst <= 1'b1;
		watch();
		rchk(2'h0, 32'h0);
		rchk(2'h1, 32'h08);
		rchk(2'h2, 32'h0);
		bus(1'b1, 2'h3, 32'hFF);
		rchk(2'h3, 32'h0);
		chk("lowv enable", 1, lv_en);
		bus(1'b1, 2'h1, 32'h28);
		@(negedge i_clk_sys);
		chk("threshold", 2, thr);
		lock <= 1'b1;
		bus(1'b1, 2'h0, 32'hE0);
		rchk(2'h0, 32'h08);
		$display("test registers done");
		for (int c = 0; c < 3; c++) begin
			bus(1'b1, 2'h1, 32'h08 | c);
			pulse(0);
			watch();
			chk("delay", (c == 2) ? 1 + DL : 1 + DS, n);
		end
		bus(1'b1, 2'h1, 32'h08);
		pulse(0);
		repeat (4) @(posedge i_clk_sys);
		pulse(0);
		watch();
		chk("restart", 1 + DS, n);
		$display("test delay done");
		bus(1'b1, 2'h1, 32'h0C);
		lock <= 1'b0;
		pulse(0);
		fork
			watch();
			begin
				repeat (40) @(negedge i_clk_sys);
				chk("fetch held", 0, vf);
				chk("core held", 1, crst);
				@(posedge i_clk_sys);
				lock <= 1'b1;
			end
		join
		chk("pll delay", 1 + DS, n);
		$display("test pll done");
		bus(1'b1, 2'h1, 32'h08);
		pulse(1);
		watch();
		chk("wdg pulse", 1, n >= WP);
		rchk(2'h0, 32'h18);
		bus(1'b1, 2'h0, 32'h10);
		rchk(2'h0, 32'h18);
		bus(1'b1, 2'h0, 32'h00);
		rchk(2'h0, 32'h08);
		pulse(1);
		watch();
		@(posedge i_clk_sys);
		lowv <= 1'b1;
		fork
			watch();
			begin
				repeat (20) @(posedge i_clk_sys);
				lowv <= 1'b0;
			end
		join
		chk("lowv hold", 1, n >= 20);
		@(posedge i_clk_sys);
		halt <= 1'b1;
		pull <= 1'b1;
		@(negedge i_clk_sys);
		chk("pin reset", 1, crst);
		fork
			watch();
			begin
				repeat (6) @(posedge i_clk_sys);
				pull <= 1'b0;
				halt <= 1'b0;
			end
		join
		chk("pin sequence", 1, n >= 1 + DS);
		rchk(2'h0, 32'h0C);
		rchk(2'h0, 32'h08);
		$display("test reset flags done");
		bus(1'b1, 2'h0, 32'h01);
		auxv <= 1'b1;
		@(posedge i_clk_sys);
		@(negedge i_clk_sys);
		chk("irq request", 1, irq);
		rchk(2'h0, 32'h0B);
		bus(1'b1, 2'h0, 32'h01);
		rchk(2'h0, 32'h0B);
		waitm <= 1'b1;
		@(negedge i_clk_sys);
		chk("wake", 1, wake);
		@(posedge i_clk_sys);
		halt <= 1'b1;
		@(negedge i_clk_sys);
		chk("no wake", 0, wake);
		bus(1'b1, 2'h0, 32'h00);
		rchk(2'h0, 32'h0B);
		halt <= 1'b0;
		waitm <= 1'b0;
		ack <= 1'b1;
		@(posedge i_clk_sys);
		ack <= 1'b0;
		@(negedge i_clk_sys);
		chk("irq cleared", 0, irq);
		bus(1'b1, 2'h1, 32'h00);
		rchk(2'h0, 32'h09);
		chk("lowv disable", 0, lv_en);
		$display("test warning done");
		end_sim();
	end
endmodule : testbench
